/* include/htc_pkg.sv */
// Purpose: shared constants and types of the hopping transmit control
// Assumes: 50 MHz system clock, apb slave with 32-bit data
// Notes: te unit is the shortest elementary pulse, other te are multiples
package htc_pkg;
   localparam int CLK_HZ = 50_000_000;
   localparam int TE_UNIT_US = 100;
   localparam int TE_UNIT_CYC = TE_UNIT_US * (CLK_HZ / 1_000_000);
   localparam int CARRIER_HZ = 40_000;
   localparam int CARR_PER_UNIT = 2 * CARRIER_HZ * TE_UNIT_US / 1_000_000;

   // register byte offsets
   localparam logic [7:0] OFS_CFG = 8'h00;
   localparam logic [7:0] OFS_ID_LO = 8'h04;
   localparam logic [7:0] OFS_ID_HI = 8'h08;
   localparam logic [7:0] OFS_CNT_A = 8'h0C;
   localparam logic [7:0] OFS_CNT_B = 8'h10;
   localparam logic [7:0] OFS_SV0 = 8'h14;
   localparam logic [7:0] OFS_SV1 = 8'h18;
   localparam logic [7:0] OFS_KEY = 8'h1C;
   localparam logic [7:0] OFS_CTRL = 8'h20;
   localparam logic [7:0] OFS_STAT = 8'h24;

   // configuration word fields
   localparam int CFG_SKIP = 0;
   localparam int CFG_RATE = 1;
   localparam int CFG_FMT = 2;
   localparam int CFG_SV_EN = 4;
   localparam int CFG_LATE = 5;
   localparam int CFG_CUT = 6;
   localparam int CFG_DUAL = 7;
   localparam int CFG_USRA = 8;
   localparam int CFG_USRB = 10;
   localparam int CFG_WIDE = 12;
   localparam int CFG_TMP = 13;
   localparam int CFG_MOD = 14;
   localparam int CFG_WRAP = 15;
   localparam logic [15:0] CFG_RST = 16'h0000;

   // status fields
   localparam int ST_BUSY = 0;
   localparam int ST_TOUT = 1;
   localparam int ST_LATE = 2;
   localparam int ST_SVDIS = 3;
   localparam int ST_WORDS = 16;

   // frame layout
   localparam int WORD_W = 99;
   localparam logic [6:0] HOP_LEN = 7'd67;
   localparam logic [6:0] SV_LEN = 7'd99;
   localparam int ENC_W = 32;
   localparam int SVD_W = 64;
   localparam logic [6:0] PRE_TE = 7'd23;
   localparam logic [6:0] HDR_TE = 7'd10;
   localparam logic [6:0] GUARD_TE = 7'd39;
   localparam logic [6:0] GUARD_TE_EXT = 7'd78;

   // word counts
   localparam logic [9:0] DELAY_WORDS_SLOW = 10'd28;
   localparam logic [9:0] DELAY_WORDS_FAST = 10'd56;
   localparam logic [9:0] CUT_WORDS_SLOW = 10'd256;
   localparam logic [9:0] CUT_WORDS_FAST = 10'd512;
   localparam logic [9:0] MIN_WORDS = 10'd2;

   // button patterns and counter split points
   localparam logic [3:0] BTN_SV_NOW = 4'h9;
   localparam logic [3:0] BTN_SV_LATE = 4'h3;
   localparam logic [3:0] BTN_SPLIT_RF = 4'h8;
   localparam logic [3:0] BTN_SPLIT_IR = 4'hC;

   // start-value lockout table
   localparam logic [15:0] LIM_V128 = 16'h0000;
   localparam logic [15:0] LIM_V64 = 16'h0060;
   localparam logic [15:0] LIM_V32 = 16'h0050;
   localparam logic [15:0] LIM_V16 = 16'h0048;
   localparam logic [7:0] LIM_N128 = 8'd128;
   localparam logic [7:0] LIM_N64 = 8'd64;
   localparam logic [7:0] LIM_N32 = 8'd32;
   localparam logic [7:0] LIM_N16 = 8'd16;

   typedef enum logic [1:0] {ST_IDLE, ST_SEND, ST_CUT} htc_state_e;
   typedef enum logic [2:0] {PH_IDLE, PH_PRE, PH_HDR, PH_DATA, PH_GRD}
      htc_phase_e;
endpackage : htc_pkg

/* hw/htc_te_gen.sv */
// Purpose: elementary pulse tick and infrared carrier generator
// Assumes: clr restarts the pulse grid at a word start
// Notes: carrier derives from the te unit, so the bit rate multiplier leaves it unchanged
`timescale 1ns/1ps
module htc_te_gen
   import htc_pkg::*;
#(
   parameter int UNIT_CYC = TE_UNIT_CYC
)
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic clr_i,
   input wire logic [2:0] mult_i,
   output logic tick_o,
   output logic carrier_o
);
   localparam int HALF = UNIT_CYC / CARR_PER_UNIT;
   localparam int CW = $clog2(UNIT_CYC);

   if (UNIT_CYC < 2 * CARR_PER_UNIT)
   begin : g_chk
      $error("te unit too short for carrier");
   end

   typedef struct packed {
      logic [CW-1:0] cyc;
      logic [2:0] units;
      logic [CW-1:0] ccyc;
      logic carr;
      logic tick;
   } te_s;

   te_s r;
   te_s n;

   always_comb
   begin
      n = r;
      n.tick = 1'b0;
      if (clr_i)
      begin
         n = '0;
      end
      else
      begin
         if (r.cyc == CW'(UNIT_CYC - 1))
         begin
            n.cyc = '0;
            if (r.units + 3'd1 >= mult_i)
            begin
               n.units = '0;
               n.tick = 1'b1;
            end
            else
            begin
               n.units = r.units + 3'd1;
            end
         end
         else
         begin
            n.cyc = r.cyc + CW'(1);
         end
         if (r.ccyc == CW'(HALF - 1))
         begin
            n.ccyc = '0;
            n.carr = ~r.carr;
         end
         else
         begin
            n.ccyc = r.ccyc + CW'(1);
         end
      end
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         r <= '0;
      else if (ce_i)
         r <= n;
   end

   assign tick_o = r.tick;
   assign carrier_o = r.carr;
endmodule : htc_te_gen

/* hw/htc_serializer.sv */
// Purpose: sends preamble, header, data bits lsb first and guard time
// Assumes: one te_i pulse per elementary pulse
// Notes: a data bit is three te: high, inverted data, low
`timescale 1ns/1ps
module htc_serializer
   import htc_pkg::*;
#(
   parameter int W = WORD_W
)
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic load_i,
   input wire logic [W-1:0] data_i,
   input wire logic [6:0] len_i,
   input wire logic [6:0] guard_i,
   input wire logic te_i,
   output logic line_o,
   output logic data_ph_o,
   output logic done_o
);
   if (W > 127)
   begin : g_chk
      $error("word too wide for bit counter");
   end

   typedef struct packed {
      htc_phase_e ph;
      logic [6:0] cnt;
      logic [1:0] sub;
      logic [W-1:0] sh;
      logic [6:0] len;
      logic [6:0] guard;
      logic line;
      logic done;
   } ser_s;

   ser_s r;
   ser_s n;

   always_comb
   begin
      n = r;
      n.done = 1'b0;
      if (load_i)
      begin
         n.ph = PH_PRE;
         n.cnt = '0;
         n.sub = '0;
         n.sh = data_i;
         n.len = len_i;
         n.guard = guard_i;
      end
      else if (te_i)
      begin
         unique case (r.ph)
            PH_IDLE:
            begin
            end
            PH_PRE:
            begin
               n.cnt = r.cnt + 7'd1;
               if (n.cnt == PRE_TE)
               begin
                  n.ph = PH_HDR;
                  n.cnt = '0;
               end
            end
            PH_HDR:
            begin
               n.cnt = r.cnt + 7'd1;
               if (n.cnt == HDR_TE)
               begin
                  n.ph = PH_DATA;
                  n.cnt = '0;
               end
            end
            PH_DATA:
            begin
               n.sub = r.sub + 2'd1;
               if (r.sub == 2'd2)
               begin
                  n.sub = '0;
                  n.sh = r.sh >> 1;
                  n.cnt = r.cnt + 7'd1;
                  if (n.cnt == r.len)
                  begin
                     n.ph = PH_GRD;
                     n.cnt = '0;
                  end
               end
            end
            PH_GRD:
            begin
               n.cnt = r.cnt + 7'd1;
               if (n.cnt == r.guard)
               begin
                  n.ph = PH_IDLE;
                  n.done = 1'b1;
               end
            end
         endcase
      end
      unique case (n.ph)
         PH_PRE: n.line = ~n.cnt[0];
         PH_DATA: n.line = (n.sub == 2'd0) | ((n.sub == 2'd1) & ~n.sh[0]);
         default: n.line = 1'b0;
      endcase
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         r <= '{ph: PH_IDLE, default: '0};
      else if (ce_i)
         r <= n;
   end

   assign line_o = r.line;
   assign data_ph_o = (r.ph == PH_DATA);
   assign done_o = r.done;
endmodule : htc_serializer

/* hw/htc_top.sv */
// Purpose: hopping code transmit control with apb configuration
// Assumes: buttons synchronous to clk_i, cipher stands outside
// Notes: encrypted part is plaintext xor key register as a stand-in
//
// The register offsets and the APB slave port were chosen for this implementation.
`timescale 1ns/1ps
// Function
// - start value off; dual counters need it off
// - start value replaces encrypted hopping part
// - 1001 now, 0011 after delay point
// - temporary option locks start value out
// - lockout count follows initial counter value
// - delayed words invert discrimination low nibble
// - delay point 28 or 56 words
// - cutoff forces output low, indicator off
// - after cutoff wait for all buttons low
// - cutoff after 256 or 512 words
// - dual: codes 8 to 15 secondary
// - single mode: primary counter always
// - infrared: 12 to 15 secondary, carrier
// - preamble, header, 67 bits (99 for a start value word), guard
// - encrypted input field assembly
// - fixed part with optional wide identity
// - finish word, at least two words
// - wake on press, sleep after release
// - new button aborts and restarts word
// - blank every second word when enabled
// - advance counter after each transmission
// - rate select sets bit rate
// - narrow identity carries buttons on top
module htc_top
   import htc_pkg::*;
#(
   parameter int ADDR_W = 8,
   parameter int TE_UNIT = TE_UNIT_CYC
)
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic ce_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   output logic [31:0] prdata_o,
   output logic pready_o,
   output logic pslverr_o,
   input wire logic [3:0] button_i,
   input wire logic low_battery_i,
   output logic serial_o,
   output logic indicator_output_n_o
);
   if (ADDR_W < 8)
   begin : g_chk
      $error("address too narrow for register map");
   end

   typedef struct packed {
      logic [15:0] cfg;
      logic [15:0] id_lo;
      logic [15:0] id_hi;
      logic [15:0] cnt_a;
      logic [15:0] cnt_b;
      logic [15:0] sv0;
      logic [15:0] sv1;
      logic [31:0] key;
      logic ir;
      htc_state_e st;
      logic [3:0] btn;
      logic [9:0] words;
      logic late;
      logic use_b;
      logic sent_hop;
      logic [7:0] hop_cnt;
      logic [7:0] lim;
      logic sv_dis;
      logic tout;
      logic load;
      logic [WORD_W-1:0] word;
      logic [6:0] len;
      logic [6:0] guard;
      logic serial;
      logic ind_n;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
   } top_s;

   top_s r;
   top_s n;

   logic te_tick;
   logic carrier;
   logic ser_line;
   logic ser_data;
   logic ser_done;

   function automatic logic [7:0] hop_limit(input logic [15:0] v);
      unique case (v)
         LIM_V64: hop_limit = LIM_N64;
         LIM_V32: hop_limit = LIM_N32;
         LIM_V16: hop_limit = LIM_N16;
         default: hop_limit = LIM_N128;
      endcase
   endfunction : hop_limit

   function automatic logic [1:0] crc2(input logic [WORD_W-1:0] d,
                                       input logic [6:0] nbits);
      logic c0;
      logic c1;
      logic t;
      c0 = 1'b0;
      c1 = 1'b0;
      for (int i = 0; i < WORD_W; i++)
      begin
         if (i < int'(nbits))
         begin
            t = c0 ^ d[i];
            c0 = t ^ c1;
            c1 = t;
         end
      end
      crc2 = {c1, c0};
   endfunction : crc2

   function automatic logic [2:0] te_mult(input logic [15:0] c);
      if (!c[CFG_MOD] && c[CFG_FMT])
         te_mult = c[CFG_RATE] ? 3'd1 : 3'd2;
      else
         te_mult = c[CFG_RATE] ? 3'd2 : 3'd4;
   endfunction : te_mult

   logic acc;
   logic hit;
   logic start_word;
   logic adv;
   logic dual_eff;
   logic late_pt;
   logic sv_req;
   logic blank;
   logic [3:0] b;
   logic [15:0] cnt;
   logic [31:0] plain;
   logic [31:0] idf;
   logic [15:0] id_top;
   logic [WORD_W-1:0] w;
   logic [31:0] rd;

   always_comb
   begin
      n = r;
      n.load = 1'b0;
      start_word = 1'b0;
      adv = 1'b0;
      b = '0;
      cnt = '0;
      plain = '0;
      idf = '0;
      id_top = '0;
      w = '0;
      late_pt = 1'b0;
      sv_req = 1'b0;
      // dual counters only without start value
      dual_eff = r.cfg[CFG_DUAL] & ~r.cfg[CFG_SV_EN];

      unique case (r.st)
         ST_IDLE:
         begin
            if (button_i != 4'h0)
            begin
               n.st = ST_SEND;
               start_word = 1'b1;
            end
         end
         ST_SEND:
         begin
            if (button_i != 4'h0 && button_i != r.btn)
            begin
               adv = 1'b1;
               start_word = 1'b1;
            end
            else if (ser_done)
            begin
               if (r.words != 10'h3FF)
                  n.words = r.words + 10'd1;
               if (r.cfg[CFG_CUT] && n.words ==
                   (r.cfg[CFG_RATE] ? CUT_WORDS_FAST : CUT_WORDS_SLOW))
               begin
                  n.st = ST_CUT;
                  n.tout = 1'b1;
                  adv = 1'b1;
               end
               else if (button_i == 4'h0 && n.words >= MIN_WORDS)
               begin
                  n.st = ST_IDLE;
                  adv = 1'b1;
               end
               else
               begin
                  start_word = 1'b1;
               end
            end
         end
         ST_CUT:
         begin
            // leave cutoff on all buttons low
            if (button_i == 4'h0)
            begin
               n.st = ST_IDLE;
               n.tout = 1'b0;
            end
         end
         default:
         begin
            n.st = ST_IDLE;
         end
      endcase

      // advance the counter once per transmission
      if (adv)
      begin
         if (r.use_b)
            n.cnt_b = r.cnt_b + 16'd1;
         else
            n.cnt_a = r.cnt_a + 16'd1;
         if ((r.use_b ? r.cnt_b : r.cnt_a) == 16'hFFFF)
            n.cfg[CFG_WRAP] = 1'b0;
         if (r.sent_hop && r.hop_cnt != 8'hFF)
            n.hop_cnt = r.hop_cnt + 8'd1;
         n.sent_hop = 1'b0;
      end

      if (r.cfg[CFG_TMP] && r.hop_cnt >= r.lim)
         n.sv_dis = 1'b1;

      if (start_word)
      begin
         if (r.st == ST_IDLE || (button_i != 4'h0 && button_i != r.btn))
         begin
            n.btn = button_i;
            n.words = '0;
            n.late = 1'b0;
         end
         b = n.btn;
         late_pt = n.words >= (r.cfg[CFG_RATE] ? DELAY_WORDS_FAST :
                               DELAY_WORDS_SLOW);
         n.late = n.late | (r.cfg[CFG_LATE] & late_pt);
         sv_req = r.cfg[CFG_SV_EN] & ~n.sv_dis &
                  ((b == BTN_SV_NOW) | ((b == BTN_SV_LATE) & late_pt));
         n.use_b = dual_eff & (b >= (r.ir ? BTN_SPLIT_IR : BTN_SPLIT_RF));
         cnt = n.use_b ? n.cnt_b : n.cnt_a;
         // buttons on top of narrow identity
         id_top = r.cfg[CFG_WIDE] ? r.id_hi : {b, r.id_hi[11:0]};
         idf = {id_top, r.id_lo};
         plain[15:0] = cnt;
         plain[23:16] = {r.id_lo[7:4], r.id_lo[3:0] ^ {4{n.late}}};
         plain[25:24] = n.use_b ? r.cfg[CFG_USRB+:2] : r.cfg[CFG_USRA+:2];
         plain[26] = r.cfg[CFG_WRAP];
         plain[27] = dual_eff;
         plain[31:28] = b;
         if (sv_req)
         begin
            w[SVD_W-1:0] = {id_top, n.cnt_b, r.sv1, r.sv0};
            w[SVD_W+:32] = idf;
            w[SVD_W+32] = low_battery_i;
            w[SVD_W+33+:2] = crc2(w, SV_LEN - 7'd2);
            n.len = SV_LEN;
         end
         else
         begin
            w[ENC_W-1:0] = plain ^ r.key;
            w[ENC_W+:32] = idf;
            w[ENC_W+32] = low_battery_i;
            w[ENC_W+33+:2] = crc2(w, HOP_LEN - 7'd2);
            n.len = HOP_LEN;
            n.sent_hop = 1'b1;
         end
         n.word = w;
         n.guard = r.cfg[CFG_MOD] ? GUARD_TE_EXT : GUARD_TE;
         n.load = 1'b1;
      end

      // apb slave, one wait state
      acc = psel_i & penable_i;
      hit = 1'b1;
      rd = '0;
      unique case (paddr_i[7:0])
         OFS_CFG: rd = {16'h0000, r.cfg};
         OFS_ID_LO: rd = {16'h0000, r.id_lo};
         OFS_ID_HI: rd = {16'h0000, r.id_hi};
         OFS_CNT_A: rd = {16'h0000, r.cnt_a};
         OFS_CNT_B: rd = {16'h0000, r.cnt_b};
         OFS_SV0: rd = {16'h0000, r.sv0};
         OFS_SV1: rd = {16'h0000, r.sv1};
         OFS_KEY: rd = r.key;
         OFS_CTRL: rd = {31'h0, r.ir};
         OFS_STAT:
         begin
            rd[ST_BUSY] = (r.st == ST_SEND);
            rd[ST_TOUT] = r.tout;
            rd[ST_LATE] = r.late;
            rd[ST_SVDIS] = r.sv_dis;
            rd[ST_WORDS+:10] = r.words;
         end
         default: hit = 1'b0;
      endcase
      if (paddr_i[ADDR_W-1:0] != ADDR_W'(paddr_i[7:0]))
         hit = 1'b0;
      n.pready = acc & ~r.pready;
      n.pslverr = acc & ~r.pready & ~hit;
      n.prdata = (acc & ~r.pready & hit & ~pwrite_i) ? rd : 32'h0;
      if (acc & r.pready & pwrite_i & hit)
      begin
         unique case (paddr_i[7:0])
            OFS_CFG: n.cfg = pwdata_i[15:0];
            OFS_ID_LO: n.id_lo = pwdata_i[15:0];
            OFS_ID_HI: n.id_hi = pwdata_i[15:0];
            OFS_CNT_A, OFS_CNT_B:
            begin
               if (paddr_i[7:0] == OFS_CNT_A)
                  n.cnt_a = pwdata_i[15:0];
               else
                  n.cnt_b = pwdata_i[15:0];
               n.lim = hop_limit(pwdata_i[15:0]);
               n.hop_cnt = '0;
            end
            OFS_SV0: n.sv0 = pwdata_i[15:0];
            OFS_SV1: n.sv1 = pwdata_i[15:0];
            OFS_KEY: n.key = pwdata_i;
            OFS_CTRL: n.ir = pwdata_i[0];
            default:
            begin
            end
         endcase
      end
      if (adv && (r.use_b ? r.cnt_b : r.cnt_a) == 16'hFFFF)
         n.cfg[CFG_WRAP] = 1'b0;

      blank = r.cfg[CFG_SKIP] & r.words[0];
      // cutoff drives serial low, indicator off
      n.serial = (r.st == ST_SEND) & ~blank & ser_line &
                 (~r.ir | carrier);
      n.ind_n = ~((r.st == ST_SEND) & ser_data & ~blank);
   end

   always_ff @(posedge clk_i or posedge sys_rst_i)
   begin
      if (sys_rst_i)
         r <= '{cfg: CFG_RST, st: ST_IDLE, lim: LIM_N128, ind_n: 1'b1,
                default: '0};
      else if (ce_i)
         r <= n;
   end

   htc_te_gen #(
      .UNIT_CYC(TE_UNIT)
   ) u_te (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .clr_i(r.load),
      .mult_i(te_mult(r.cfg)),
      .tick_o(te_tick),
      .carrier_o(carrier)
   );

   htc_serializer #(
      .W(WORD_W)
   ) u_ser (
      .clk_i(clk_i),
      .sys_rst_i(sys_rst_i),
      .ce_i(ce_i),
      .load_i(r.load),
      .data_i(r.word),
      .len_i(r.len),
      .guard_i(r.guard),
      .te_i(te_tick),
      .line_o(ser_line),
      .data_ph_o(ser_data),
      .done_o(ser_done)
   );

   assign prdata_o = r.prdata;
   assign pready_o = r.pready;
   assign pslverr_o = r.pslverr;
   assign serial_o = r.serial;
   assign indicator_output_n_o = r.ind_n;
endmodule : htc_top

/* verif/htc_top_assertions.sv */
// Purpose: port assertions for htc_top
// Assumes: ce_i held high
// Notes: bound to every htc_top
`timescale 1ns/1ps
module htc_top_assertions
#(
   parameter int ADDR_W = 8
)
(
   input wire logic clk_i,
   input wire logic sys_rst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic [ADDR_W-1:0] paddr_i,
   input wire logic [31:0] prdata_o,
   input wire logic pready_o,
   input wire logic pslverr_o,
   input wire logic serial_o,
   input wire logic indicator_output_n_o
);
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (sys_rst_i);
   a_ready_one_wait: assert property (psel_i && !penable_i
      |=> !pready_o ##1 pready_o) else $error("late pready");
   a_ready_single: assert property (pready_o |=> !pready_o)
      else $error("pready too long");
   a_ready_from_access: assert property
      (pready_o |-> $past(psel_i && penable_i)) else $error("stray pready");
   a_err_with_ready: assert property (pslverr_o |-> pready_o)
      else $error("pslverr alone");
   a_rdata_idle: assert property (!pready_o |-> prdata_o == 32'h0)
      else $error("prdata not zero");
   a_unmapped_err: assert property (pready_o && paddr_i > 8'h24
      |-> pslverr_o) else $error("no pslverr");
   a_data_block: assert property ($fell(indicator_output_n_o)
      |=> !indicator_output_n_o [*8]) else $error("short data phase");
   a_bit_pulse: assert property ($fell(indicator_output_n_o)
      |-> ##[0:200] serial_o) else $error("no bit pulse");
endmodule : htc_top_assertions

bind htc_top htc_top_assertions #(.ADDR_W(ADDR_W)) chk_u (.clk_i(clk_i),
   .sys_rst_i(sys_rst_i), .psel_i(psel_i), .penable_i(penable_i),
   .paddr_i(paddr_i), .prdata_o(prdata_o), .pready_o(pready_o),
   .pslverr_o(pslverr_o), .serial_o(serial_o),
   .indicator_output_n_o(indicator_output_n_o));

/* verif/htc_rx_model.sv */
// Purpose: receiver model decoding the serial line
// Assumes: no carrier, te of TE_CYC clocks
// Notes: one rising edge a bit, sampled mid-bit
`timescale 1ns/1ps
module htc_rx_model
#(
   parameter int TE_CYC = 16
)
(
   input wire logic clk_i,
   input wire logic serial_i,
   input wire logic ind_n_i,
   output logic [98:0] bits_o,
   output int nbits_o,
   output int words_o
);
   logic prev;
   logic pind;
   int cnt;
   initial
   begin
      bits_o = '0;
      nbits_o = 0;
      words_o = 0;
      prev = 1'b0;
      pind = 1'b1;
      cnt = 0;
   end
   always @(posedge clk_i)
   begin
      prev <= serial_i;
      pind <= ind_n_i;
      if (pind && !ind_n_i)
         nbits_o <= 0;
      if (!pind && ind_n_i)
         words_o <= words_o + 1;
      if (serial_i && !prev)
         cnt <= 1;
      else if (cnt != 0)
         cnt <= cnt + 1;
      if (cnt == TE_CYC * 3 / 2 && !ind_n_i)
      begin
         bits_o[nbits_o] <= ~serial_i;
         nbits_o <= nbits_o + 1;
      end
   end
endmodule : htc_rx_model

/* verif/hopping_code_transmit_control_tb_top.sv */
// Purpose: self-checking bench for htc_top
// Assumes: rate and format bits set, te of one unit
// Notes: key 0 so the encrypted part shows plain fields
`timescale 1ns/1ps
module hopping_code_transmit_control_tb_top
   import htc_pkg::*;
   ;
   localparam int TU = 16;
   logic clk_i = 1'b0;
   logic sys_rst_i = 1'b1;
   logic psel = 1'b0;
   logic penable = 1'b0;
   logic pwrite = 1'b0;
   logic [7:0] paddr = 8'h00;
   logic [31:0] pwdata = 32'h0;
   logic [31:0] prdata;
   logic pready, pslverr, serial, ind_n, e;
   logic low_bat = 1'b0;
   logic ce = 1'b1;
   logic [3:0] button = 4'h0;
   logic [98:0] bits;
   logic [31:0] q;
   int nbits, words, n_errors = 0, check_count = 0;

   htc_top #(.TE_UNIT(TU)) dut_u (.clk_i(clk_i), .sys_rst_i(sys_rst_i),
      .ce_i(ce), .psel_i(psel), .penable_i(penable), .pwrite_i(pwrite),
      .paddr_i(paddr), .pwdata_i(pwdata), .prdata_o(prdata),
      .pready_o(pready), .pslverr_o(pslverr), .button_i(button),
      .low_battery_i(low_bat), .serial_o(serial),
      .indicator_output_n_o(ind_n));
   htc_rx_model #(.TE_CYC(TU)) rx_u (.clk_i(clk_i), .serial_i(serial),
      .ind_n_i(ind_n), .bits_o(bits), .nbits_o(nbits), .words_o(words));

   initial
   begin
      forever #10 clk_i = ~clk_i;
   end

   task automatic stop_test();
      $display("checks %0d errors %0d", check_count, n_errors);
      if (n_errors == 0 && check_count > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : stop_test

   task automatic chk(input logic [98:0] got, input logic [98:0] exp);
      check_count++;
      if (got !== exp)
      begin
         n_errors++;
         $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask : chk

   task automatic apb(input logic w, input logic [7:0] a,
      input logic [31:0] d);
      int i;
      psel <= 1'b1;
      pwrite <= w;
      paddr <= a;
      pwdata <= d;
      @(posedge clk_i);
      penable <= 1'b1;
      i = 0;
      do
      begin
         @(posedge clk_i);
         i++;
      end
      while (pready !== 1'b1 && i < 50);
      q = prdata;
      e = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk_i);
      if (i >= 50)
      begin
         n_errors++;
         stop_test();
      end
   endtask : apb

   task automatic press(input logic [3:0] b);
      int i;
      button <= b;
      repeat (3) @(posedge clk_i);
      button <= 4'h0;
      i = 0;
      do
      begin
         apb(1'b0, OFS_STAT, 32'h0);
         i++;
      end
      while (q[ST_BUSY] !== 1'b0 && i < 9000);
      if (i >= 9000)
      begin
         n_errors++;
         stop_test();
      end
   endtask : press

   task automatic t_regs();
      apb(1'b0, OFS_CFG, 32'h0);
      chk(q, 32'h0);
      apb(1'b1, OFS_CFG, 32'h0006);
      apb(1'b0, OFS_CFG, 32'h0);
      chk(q, 32'h0006);
      apb(1'b0, 8'h30, 32'h0);
      chk({e, q}, {1'b1, 32'h0});
      $display("t_regs done");
   endtask : t_regs

   task automatic t_hop();
      int w0;
      apb(1'b1, OFS_ID_LO, 32'h5A3C);
      apb(1'b1, OFS_ID_HI, 32'h0B71);
      apb(1'b1, OFS_CNT_A, 32'h1234);
      apb(1'b1, OFS_KEY, 32'h0);
      low_bat <= 1'b1;
      w0 = words;
      press(4'h1);
      chk(words - w0, 2);
      chk(nbits, 67);
      chk(bits[64:0], {1'b1, 4'h1, 12'hB71, 16'h5A3C,
         8'h10, 8'h3C, 16'h1234});
      apb(1'b0, OFS_CNT_A, 32'h0);
      chk(q, 32'h1235);
      $display("t_hop done");
   endtask : t_hop

   task automatic t_seed();
      apb(1'b1, OFS_SV0, 32'h1111);
      apb(1'b1, OFS_SV1, 32'h2222);
      apb(1'b1, OFS_CNT_B, 32'h3333);
      apb(1'b1, OFS_CFG, 32'h0016);
      low_bat <= 1'b0;
      press(4'h9);
      chk(nbits, 99);
      chk(bits[47:0], 48'h333322221111);
      $display("t_seed done");
   endtask : t_seed

   task automatic t_dual();
      apb(1'b1, OFS_CNT_A, 32'h0100);
      apb(1'b1, OFS_CNT_B, 32'h4444);
      apb(1'b1, OFS_CFG, 32'h1086);
      press(4'h9);
      chk(nbits, 67);
      chk(bits[63:0], {32'h0B715A3C, 8'h98, 8'h3C, 16'h4444});
      apb(1'b0, OFS_CNT_B, 32'h0);
      chk(q, 32'h4445);
      apb(1'b0, OFS_CNT_A, 32'h0);
      chk(q, 32'h0100);
      $display("t_dual done");
   endtask : t_dual

   task automatic t_freeze();
      ce <= 1'b0;
      button <= 4'h2;
      repeat (3) @(posedge clk_i);
      button <= 4'h0;
      ce <= 1'b1;
      @(posedge clk_i);
      apb(1'b0, OFS_STAT, 32'h0);
      chk(q[ST_BUSY], 1'b0);
      $display("t_freeze done");
   endtask : t_freeze

   task automatic t_abort();
      apb(1'b1, OFS_CFG, 32'h0006);
      apb(1'b1, OFS_CNT_A, 32'h0200);
      button <= 4'h1;
      repeat (3) @(posedge clk_i);
      press(4'h2);
      chk(bits[31:0], {8'h20, 8'h3C, 16'h0201});
      apb(1'b0, OFS_CNT_A, 32'h0);
      chk(q, 32'h0202);
      $display("t_abort done");
   endtask : t_abort

   task automatic t_blank();
      int w0;
      apb(1'b1, OFS_CFG, 32'h0007);
      w0 = words;
      press(4'h1);
      chk(words - w0, 1);
      chk(nbits, 67);
      $display("t_blank done");
   endtask : t_blank

   initial
   begin
      repeat (6) @(posedge clk_i);
      sys_rst_i <= 1'b0;
      @(posedge clk_i);
      t_regs();
      t_freeze();
      t_hop();
      t_seed();
      t_dual();
      t_abort();
      t_blank();
      stop_test();
   end
endmodule : hopping_code_transmit_control_tb_top
